/* File: rtl/iri_pkg.sv */
// Register map, field positions, timing and state types of the indirect remote I2C engine
package iri_pkg;
   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_IRQ_CTL = 8'hc6;
   localparam logic [7:0] ADDR_IRQ_STS = 8'hc7;
   localparam logic [7:0] ADDR_STS_CTL = 8'hd0;
   localparam logic [7:0] ADDR_TGT     = 8'hd1;
   localparam logic [7:0] ADDR_OFS     = 8'hd2;
   localparam logic [7:0] ADDR_DATA    = 8'hd3;
   localparam logic [7:0] REG_RESET    = 8'h00;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_MRESET  = 7;
   localparam int BIT_TODIS   = 5;
   localparam int BIT_FAST    = 4;
   localparam int BIT_ACK     = 1;
   localparam int BIT_DONE    = 0;
   localparam int BIT_DIR     = 0;
   localparam int BIT_IRQ_SRC = 7;
   localparam int BIT_IRQ_GLB = 0;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS   = 100;
   localparam int STD_QUARTER_NS  = 2500;
   localparam int FAST_QUARTER_NS = 625;
   localparam int STD_QUARTER_CYC =
      (STD_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int FAST_QUARTER_CYC =
      (FAST_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUS_TIMEOUT_MS  = 1000;
   localparam int BUS_TIMEOUT_CYC = BUS_TIMEOUT_MS * (1000000 / CLK_PERIOD_NS);
   localparam int QCNT_W          = 5;
   localparam int TOCNT_W         = 24;
   // ------------------------------------------------------------
   // Frame sequencing
   // ------------------------------------------------------------
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [1:0] SEG_ADDR = 2'h0;
   localparam logic [1:0] SEG_OFS  = 2'h1;
   localparam logic [1:0] SEG_DATA = 2'h2;
   localparam logic [1:0] SEG_RX   = 2'h3;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'h0,
      ST_START  = 3'h1,
      ST_BIT    = 3'h3,
      ST_STOP   = 3'h2,
      ST_RSTART = 3'h6
   } iri_state_type;
endpackage

/* File: rtl/iri_eng_if.sv */
// Interface between the register front end and the bus engine
`timescale 1ns/1ps
interface iri_eng_if;
   logic       ce;
   logic       go;
   logic       mreset;
   logic       fast;
   logic       to_dis;
   logic       rw;
   logic [6:0] addr;
   logic [7:0] offset;
   logic [7:0] wdata;
   logic       scl_in;
   logic       sda_in;
   logic       busy;
   logic       done;
   logic       ack;
   logic [7:0] rdata;
   logic       scl_oe;
   logic       sda_oe;
   modport ctl (output ce, go, mreset, fast, to_dis, rw, addr, offset, wdata, scl_in, sda_in,
                input  busy, done, ack, rdata, scl_oe, sda_oe);
   modport eng (input  ce, go, mreset, fast, to_dis, rw, addr, offset, wdata, scl_in, sda_in,
                output busy, done, ack, rdata, scl_oe, sda_oe);
endinterface

/* File: rtl/iri_engine.sv */
// Bit-level I2C master that runs one indirect access on the far-side bus
`timescale 1ns/1ps
module iri_engine
   import iri_pkg::*;
#(
   parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_n_i,
   // Front end and pins
   iri_eng_if.eng   eng
);
   iri_state_type      st_q;
   logic [1:0]         ph_q;
   logic [3:0]         bit_q;
   logic [1:0]         seg_q;
   logic [8:0]         sh_q;
   logic [7:0]         rx_q;
   logic               ok_q;
   logic [QCNT_W-1:0]  qcnt_q;
   logic [TOCNT_W-1:0] to_cnt_q;
   logic               scl_prev_q, sda_prev_q;
   logic               done_q, ack_q, scl_oe_q, sda_oe_q;
   logic [7:0]         rdata_q;
   logic               wait_w, tick_w, to_hit_w, last_w, scl_lo, sda_lo;
   logic [QCNT_W-1:0]  reload_w;

   function automatic logic [7:0] seg_byte(input logic [1:0] s, input logic rw,
                                           input logic [6:0] a, input logic [7:0] o,
                                           input logic [7:0] w);
      case (s)
         SEG_ADDR: seg_byte = {a, 1'b0};
         SEG_OFS:  seg_byte = o;
         SEG_DATA: seg_byte = rw ? {a, 1'b1} : w;
         default:  seg_byte = 8'hff;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Quarter-bit timing and stretch wait
   // ------------------------------------------------------------
   assign reload_w = eng.fast ? QCNT_W'(FAST_QUARTER_CYC - 1)
                              : QCNT_W'(STD_QUARTER_CYC - 1);
   assign wait_w   = (st_q == ST_START && ph_q == 2'h0 && !(eng.scl_in && eng.sda_in)) ||
                     (st_q != ST_IDLE && st_q != ST_START && ph_q == 2'h1 && !eng.scl_in);
   assign tick_w   = st_q != ST_IDLE && qcnt_q == '0 && !wait_w;
   // Only waits count toward the timeout, so a slow but moving bus never trips it
   assign to_hit_w = wait_w && !eng.to_dis && to_cnt_q == TOCNT_W'(TIMEOUT_CYC - 1);
   assign last_w   = (seg_q == SEG_DATA && !eng.rw) || seg_q == SEG_RX;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         qcnt_q <= '0;
      end else if (eng.ce) begin
         if (eng.mreset || st_q == ST_IDLE || tick_w) begin
            qcnt_q <= reload_w;
         end else if (qcnt_q != '0) begin
            qcnt_q <= qcnt_q - QCNT_W'(1);
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         to_cnt_q   <= '0;
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end else if (eng.ce) begin
         scl_prev_q <= eng.scl_in;
         sda_prev_q <= eng.sda_in;
         if (!wait_w || eng.scl_in != scl_prev_q || eng.sda_in != sda_prev_q) begin
            to_cnt_q <= '0;
         end else if (to_cnt_q != '1) begin
            to_cnt_q <= to_cnt_q + TOCNT_W'(1);
         end
      end
   end

   // ------------------------------------------------------------
   // Frame sequencer
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         st_q    <= ST_IDLE;
         ph_q    <= 2'h0;
         bit_q   <= 4'h0;
         seg_q   <= SEG_ADDR;
         sh_q    <= 9'h1ff;
         rx_q    <= 8'h00;
         ok_q    <= 1'b0;
         done_q  <= 1'b0;
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else if (eng.ce) begin
         done_q <= 1'b0;
         if (eng.mreset) begin
            st_q <= ST_IDLE;
            ph_q <= 2'h0;
         end else if (to_hit_w) begin
            st_q   <= ST_IDLE;
            ph_q   <= 2'h0;
            done_q <= 1'b1;
            ack_q  <= 1'b0;
         end else if (st_q == ST_IDLE) begin
            if (eng.go) begin
               st_q  <= ST_START;
               ph_q  <= 2'h0;
               seg_q <= SEG_ADDR;
               ok_q  <= 1'b1;
               rx_q  <= 8'h00;
            end
         end else if (tick_w) begin
            ph_q <= ph_q + 2'h1;
            if (st_q == ST_BIT && ph_q == 2'h1) begin
               if (bit_q == ACK_SLOT && seg_q != SEG_RX && eng.sda_in) begin
                  ok_q <= 1'b0;
               end
               if (bit_q != ACK_SLOT && seg_q == SEG_RX) begin
                  rx_q <= {rx_q[6:0], eng.sda_in};
               end
            end
            if (ph_q == 2'h3) begin
               case (st_q)
                  ST_START, ST_RSTART: begin
                     st_q  <= ST_BIT;
                     bit_q <= 4'h0;
                     sh_q  <= {seg_byte(seg_q, eng.rw, eng.addr, eng.offset, eng.wdata), 1'b1};
                  end
                  ST_BIT: begin
                     if (bit_q != ACK_SLOT) begin
                        bit_q <= bit_q + 4'h1;
                        sh_q  <= {sh_q[7:0], 1'b1};
                     end else if (!ok_q || last_w) begin
                        st_q <= ST_STOP;
                     end else if (seg_q == SEG_OFS && eng.rw) begin
                        st_q  <= ST_RSTART;
                        seg_q <= SEG_DATA;
                     end else begin
                        seg_q <= seg_q + 2'h1;
                        bit_q <= 4'h0;
                        sh_q  <= {seg_byte(seg_q + 2'h1, eng.rw, eng.addr, eng.offset,
                                           eng.wdata), 1'b1};
                     end
                  end
                  ST_STOP: begin
                     st_q    <= ST_IDLE;
                     done_q  <= 1'b1;
                     ack_q   <= ok_q;
                     rdata_q <= rx_q;
                  end
                  default: st_q <= ST_IDLE;
               endcase
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Open-drain pin drive
   // ------------------------------------------------------------
   always_comb begin
      scl_lo = 1'b0;
      sda_lo = 1'b0;
      case (st_q)
         ST_START: begin
            scl_lo = ph_q[1];
            sda_lo = ph_q != 2'h0;
         end
         ST_BIT: begin
            scl_lo = ph_q == 2'h0 || ph_q == 2'h3;
            sda_lo = !sh_q[8];
         end
         ST_RSTART: begin
            scl_lo = ph_q == 2'h0 || ph_q == 2'h3;
            sda_lo = ph_q[1];
         end
         ST_STOP: begin
            scl_lo = ph_q == 2'h0;
            sda_lo = !ph_q[1];
         end
         default: begin
            scl_lo = 1'b0;
         end
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (eng.ce) begin
         // Releasing mid-frame may strand a slave; that is the price of the reset
         scl_oe_q <= scl_lo && !eng.mreset && !to_hit_w;
         sda_oe_q <= sda_lo && !eng.mreset && !to_hit_w;
      end
   end

   assign eng.busy   = st_q != ST_IDLE;
   assign eng.done   = done_q;
   assign eng.ack    = ack_q;
   assign eng.rdata  = rdata_q;
   assign eng.scl_oe = scl_oe_q;
   assign eng.sda_oe = sda_oe_q;

   a_reset_release: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng.ce && eng.mreset) |=> (!scl_oe_q && !sda_oe_q && st_q == ST_IDLE))
      else $error("master reset did not release the bus");
   a_quarter_len: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng.ce && tick_w && !eng.mreset) |=>
      qcnt_q == ($past(eng.fast) ? QCNT_W'(FAST_QUARTER_CYC - 1)
                                 : QCNT_W'(STD_QUARTER_CYC - 1)))
      else $error("quarter period does not match speed select");
   a_timeout_abort: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng.ce && to_hit_w && !eng.mreset) |=> (st_q == ST_IDLE && done_q && !ack_q))
      else $error("bus timeout did not end the access");
   a_timeout_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng.ce && eng.to_dis && st_q != ST_STOP) |=> !done_q)
      else $error("timeout fired while disabled");
   a_frame_start: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (eng.ce && eng.go && st_q == ST_IDLE && !eng.mreset) |=>
      (st_q == ST_START && ph_q == 2'h0))
      else $error("access did not begin with a start condition");
endmodule // iri_engine

/* File: rtl/iri_top.sv */
// Register front end of the indirect remote I2C access block
`timescale 1ns/1ps
module iri_top
   import iri_pkg::*;
#(
   parameter int TIMEOUT_CYC = BUS_TIMEOUT_CYC
) (
   // Clock, reset, enable
   input  wire logic       sys_clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // Register port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic       reg_rd_i,
   input  wire logic [7:0] reg_wdata_i,
   output logic      [7:0] reg_rdata_o,
   // Interrupt to controller
   output logic            int_o,
   // Far-side bus pins
   input  wire logic       scl_i,
   output logic            scl_o,
   output logic            scl_oe_o,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o
);
   logic       mreset_q, todis_q, fast_q, done_q, ack_q;
   logic [7:0] tgt_q, ofs_q, data_q, rdata_q;
   logic       ie_src_q, ie_glb_q, irq_src_q, int_q, go_q, drv_lvl_q;
   logic       scl_s1_q, scl_s2_q, sda_s1_q, sda_s2_q;
   logic       wr_w, rd_sts_w, rd_isr_w, start_w, idle_w;

   iri_eng_if eng_if ();

   iri_engine #(
      .TIMEOUT_CYC (TIMEOUT_CYC)
   ) u_engine (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .eng       (eng_if.eng)
   );

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         scl_s1_q <= 1'b1;
         scl_s2_q <= 1'b1;
         sda_s1_q <= 1'b1;
         sda_s2_q <= 1'b1;
      end else if (ce_i) begin
         scl_s1_q <= scl_i;
         scl_s2_q <= scl_s1_q;
         sda_s1_q <= sda_i;
         sda_s2_q <= sda_s1_q;
      end
   end

   // ------------------------------------------------------------
   // Register writes
   // ------------------------------------------------------------
   assign idle_w   = !eng_if.busy && !go_q;
   assign wr_w     = ce_i && reg_wr_i;
   assign rd_sts_w = ce_i && reg_rd_i && reg_addr_i == ADDR_STS_CTL;
   assign rd_isr_w = ce_i && reg_rd_i && reg_addr_i == ADDR_IRQ_STS;
   // Access parameters are frozen in flight so the engine never sees a torn frame
   assign start_w  = wr_w && reg_addr_i == ADDR_TGT && idle_w && !mreset_q;

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         mreset_q <= REG_RESET[BIT_MRESET];
         todis_q  <= REG_RESET[BIT_TODIS];
         fast_q   <= REG_RESET[BIT_FAST];
         tgt_q    <= REG_RESET;
         ofs_q    <= REG_RESET;
         ie_src_q <= REG_RESET[BIT_IRQ_SRC];
         ie_glb_q <= REG_RESET[BIT_IRQ_GLB];
         go_q     <= 1'b0;
      end else if (ce_i) begin
         go_q <= start_w;
         if (wr_w && reg_addr_i == ADDR_STS_CTL) begin
            mreset_q <= reg_wdata_i[BIT_MRESET];
            todis_q  <= reg_wdata_i[BIT_TODIS];
            fast_q   <= reg_wdata_i[BIT_FAST];
         end
         if (start_w) begin
            tgt_q <= reg_wdata_i;
         end
         if (wr_w && reg_addr_i == ADDR_OFS && idle_w) begin
            ofs_q <= reg_wdata_i;
         end
         if (wr_w && reg_addr_i == ADDR_IRQ_CTL) begin
            ie_src_q <= reg_wdata_i[BIT_IRQ_SRC];
            ie_glb_q <= reg_wdata_i[BIT_IRQ_GLB];
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         data_q <= REG_RESET;
      end else if (ce_i) begin
         if (eng_if.done && eng_if.ack && tgt_q[BIT_DIR]) begin
            data_q <= eng_if.rdata;
         end else if (wr_w && reg_addr_i == ADDR_DATA && idle_w) begin
            data_q <= reg_wdata_i;
         end
      end
   end

   // ------------------------------------------------------------
   // Status flags
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         done_q    <= REG_RESET[BIT_DONE];
         ack_q     <= REG_RESET[BIT_ACK];
         irq_src_q <= 1'b0;
         int_q     <= 1'b0;
      end else if (ce_i) begin
         // Completion beats a clear in the same cycle
         if (eng_if.done) begin
            done_q <= 1'b1;
         end else if (rd_sts_w || start_w) begin
            done_q <= 1'b0;
         end
         if (eng_if.done) begin
            ack_q <= eng_if.ack;
         end else if (start_w) begin
            ack_q <= 1'b0;
         end
         if (eng_if.done) begin
            irq_src_q <= 1'b1;
         end else if (rd_isr_w) begin
            irq_src_q <= 1'b0;
         end
         int_q <= irq_src_q && ie_src_q && ie_glb_q;
      end
   end

   // ------------------------------------------------------------
   // Register reads
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (!rst_n_i) begin
         rdata_q   <= 8'h00;
         drv_lvl_q <= 1'b0;
      end else if (ce_i && reg_rd_i) begin
         if (reg_addr_i == ADDR_STS_CTL) begin
            rdata_q <= {mreset_q, 1'b0, todis_q, fast_q, 2'h0, ack_q, done_q};
         end else if (reg_addr_i == ADDR_TGT) begin
            rdata_q <= tgt_q;
         end else if (reg_addr_i == ADDR_OFS) begin
            rdata_q <= ofs_q;
         end else if (reg_addr_i == ADDR_DATA) begin
            rdata_q <= data_q;
         end else if (reg_addr_i == ADDR_IRQ_CTL) begin
            rdata_q <= {ie_src_q, 6'h00, ie_glb_q};
         end else if (reg_addr_i == ADDR_IRQ_STS) begin
            rdata_q <= {irq_src_q, 6'h00, irq_src_q && ie_src_q};
         end else begin
            rdata_q <= 8'h00;
         end
      end
   end

   assign eng_if.ce     = ce_i;
   assign eng_if.go     = go_q;
   assign eng_if.mreset = mreset_q;
   assign eng_if.fast   = fast_q;
   assign eng_if.to_dis = todis_q;
   assign eng_if.rw     = tgt_q[BIT_DIR];
   assign eng_if.addr   = tgt_q[7:1];
   assign eng_if.offset = ofs_q;
   assign eng_if.wdata  = data_q;
   assign eng_if.scl_in = scl_s2_q;
   assign eng_if.sda_in = sda_s2_q;

   assign reg_rdata_o = rdata_q;
   assign int_o       = int_q;
   assign scl_o       = drv_lvl_q;
   assign sda_o       = drv_lvl_q;
   assign scl_oe_o    = eng_if.scl_oe;
   assign sda_oe_o    = eng_if.sda_oe;

   a_done_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && eng_if.done) |=> done_q)
      else $error("done flag not set on completion");
   a_done_rd_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (rd_sts_w && !eng_if.done) |=> !done_q)
      else $error("status read did not clear done");
   a_done_go_clr: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (start_w && !eng_if.done) |=> !done_q)
      else $error("new access did not clear done");
   a_ack_capture: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && eng_if.done) |=> ack_q == $past(eng_if.ack))
      else $error("ack flag does not match the access result");
   a_rdata_load: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && eng_if.done && eng_if.ack && tgt_q[BIT_DIR]) |=>
      data_q == $past(eng_if.rdata))
      else $error("read byte not placed in data register");
   a_irq_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && irq_src_q && ie_src_q && ie_glb_q) |=> int_o)
      else $error("enabled completion did not raise the interrupt");
   a_irq_off: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && !ie_glb_q) ##1 !ie_glb_q |-> !int_o)
      else $error("interrupt driven while globally disabled");
   a_irq_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
      (ce_i && eng_if.done) |=> irq_src_q)
      else $error("completion status not flagged");
endmodule // iri_top

/* File: tb/iri_slave_model.sv */
// Behavioural far-side I2C slave with a byte memory
`timescale 1ns/1ps
module iri_slave_model #(
   parameter logic [6:0] SADDR = 7'h2a
) (
   // Bus levels and stretch request
   input  wire logic scl_i,
   input  wire logic sda_i,
   input  wire logic slow_i,
   // Open-drain pulls
   output logic      scl_oe_o,
   output logic      sda_oe_o
);
   logic [7:0] mem [256];
   logic [7:0] sh;
   logic [7:0] ofs;
   logic       sel;
   int         bn;
   int         ph;
   initial begin
      foreach (mem[i]) mem[i] = 8'h00;
      scl_oe_o = 1'b0;
      sda_oe_o = 1'b0;
      sel      = 1'b0;
      bn       = 0;
      ph       = 0;
   end
   // Start resets framing, stop drops selection
   always @(negedge sda_i) if (scl_i) begin
      bn = 0;
      ph = 0;
   end
   always @(posedge sda_i) if (scl_i) sel = 1'b0;
   // Master NACK after a read byte ends our driving
   always @(posedge scl_i) begin
      if (bn < 8) sh = {sh[6:0], sda_i};
      else if (ph == 3 && sda_i) sel = 1'b0;
      bn = bn + 1;
   end
   // Data changes only while the clock is low
   always @(negedge scl_i) begin
      sda_oe_o = 1'b0;
      if (bn == 9) bn = 0;
      if (bn == 8 && ph != 3) begin
         if (ph == 0) sel = (sh[7:1] == SADDR);
         else if (ph == 1) ofs = sh;
         else if (sel) mem[ofs] = sh;
         sda_oe_o = sel;
         ph = (ph == 0 && sh[0]) ? 3 : (ph == 2 ? 2 : ph + 1);
         if (slow_i) begin
            scl_oe_o = 1'b1;
            #2000 scl_oe_o = 1'b0;
         end
      end else if (ph == 3 && bn < 8 && sel) sda_oe_o = !mem[ofs][7-bn];
   end
endmodule // iri_slave_model

/* File: tb/indirect_remote_i2c_access_tb.sv */
// Self-checking bench of the indirect remote I2C access block
`timescale 1ns/1ps
module indirect_remote_i2c_access_tb;
   import iri_pkg::*;
   logic       clk = 1'b0;
   logic       ce = 1'b1;
   logic       scl_lv;
   logic       sda_lv;
   logic       rst_n = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] rdata;
   logic       wr = 1'b0;
   logic       rd = 1'b0;
   logic       irq;
   logic       stuck = 1'b0;
   logic       slow = 1'b0;
   logic       fast = 1'b0;
   logic       todis = 1'b0;
   logic       scl_oe;
   logic       sda_oe;
   logic       s_scl_oe;
   logic       s_sda_oe;
   wire logic  scl = !(scl_oe | s_scl_oe | stuck);
   wire logic  sda = !(sda_oe | s_sda_oe);
   int         mismatches = 0;
   int         checks_done = 0;
   int         seed = 32'hd909;
   int         cyc;
   logic [7:0] o;
   logic [7:0] d;
   logic [7:0] regs [7] = '{ADDR_IRQ_CTL, ADDR_IRQ_STS, ADDR_STS_CTL, ADDR_TGT,
                            ADDR_OFS, ADDR_DATA, 8'hd4};
   initial forever #50 clk = ~clk;
   iri_top #(.TIMEOUT_CYC(200)) u_iri_top (
      .sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .int_o(irq), .scl_i(scl), .scl_o(scl_lv), .scl_oe_o(scl_oe), .sda_i(sda),
      .sda_o(sda_lv), .sda_oe_o(sda_oe));
   iri_slave_model u_iri_slave_model (
      .scl_i(scl), .sda_i(sda), .slow_i(slow), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe));
   // ------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      checks_done++;
      if (s !== e) begin
         mismatches++;
         $display("unexpected %s: expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [7:0] sts(input logic a, input logic dn);
      return {2'b00, todis, fast, 2'b00, a, dn};
   endfunction
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      #1 addr = a;
      wdata = v;
      wr = 1'b1;
      @(posedge clk);
      #1 wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      #1 addr = a;
      rd = 1'b1;
      @(posedge clk);
      #1 rd = 1'b0;
      chk("read data", rdata, e);
   endtask
   // Waits for completion, then checks flags and their clearing
   task automatic fin(input logic ak);
      cyc = 0;
      while (irq !== 1'b1 && cyc < 20000) begin
         @(posedge clk);
         #1 cyc++;
      end
      if (cyc == 20000) begin
         mismatches++;
         end_sim();
      end
      rd_chk(ADDR_IRQ_STS, 8'h81);
      @(posedge clk);
      #1 chk("interrupt", {7'h00, irq}, 8'h00);
      rd_chk(ADDR_STS_CTL, sts(ak, 1'b1));
      rd_chk(ADDR_STS_CTL, sts(ak, 1'b0));
   endtask
   task automatic acc(input logic [7:0] t, input logic [7:0] ov, input logic [7:0] dv,
                      input logic ak);
      wr_reg(ADDR_OFS, ov);
      wr_reg(ADDR_DATA, dv);
      wr_reg(ADDR_TGT, t);
      fin(ak);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'b1;
      foreach (regs[i]) rd_chk(regs[i], 8'h00);
      wr_reg(ADDR_IRQ_CTL, 8'h81);
      // Writes then reads back, both timings, prompt and stretching slave
      for (int i = 0; i < 4; i++) begin
         fast = i[0];
         slow = i[1];
         wr_reg(ADDR_STS_CTL, {3'b000, fast, 4'h0});
         o = 8'($random(seed));
         d = 8'($random(seed));
         acc({7'h2a, 1'b0}, o, d, 1'b1);
         chk("frame time", {7'h00, fast ? cyc < 2700 : cyc >= 2700}, 8'h01);
         chk("slave byte", u_iri_slave_model.mem[o], d);
         acc({7'h2a, 1'b1}, o, ~d, 1'b1);
         rd_chk(ADDR_DATA, d);
      end
      slow = 1'b0;
      acc({7'h15, 1'b0}, 8'h10, 8'h55, 1'b0);
      // Stuck clock line: timeout aborts, then disabled timeout waits
      stuck = 1'b1;
      acc({7'h2a, 1'b0}, 8'h20, 8'h66, 1'b0);
      todis = 1'b1;
      wr_reg(ADDR_STS_CTL, {2'b00, todis, fast, 4'h0});
      wr_reg(ADDR_TGT, 8'h54);
      repeat (400) @(posedge clk);
      #1 chk("interrupt", {7'h00, irq}, 8'h00);
      stuck = 1'b0;
      fin(1'b1);
      // Frozen clock enable drops a write
      ce = 1'b0;
      wr_reg(ADDR_STS_CTL, 8'h80);
      ce = 1'b1;
      rd_chk(ADDR_STS_CTL, sts(1'b1, 1'b0));
      // Master held in reset ignores a start
      wr_reg(ADDR_STS_CTL, 8'h80);
      wr_reg(ADDR_TGT, 8'h54);
      repeat (100) @(posedge clk);
      rd_chk(ADDR_STS_CTL, 8'h82);
      chk("pin drive", {6'h00, scl_oe, sda_oe}, 8'h00);
      chk("pin level", {6'h00, scl_lv, sda_lv}, 8'h00);
      end_sim();
   end
endmodule // indirect_remote_i2c_access_tb
